/* File: hdl/deser_global_pkg.sv */
/*
 * constants of the shared control and identification register bank: offsets, field positions,
 * reset values, timing and control states.
 * assumes a 50 MHz device clock and 8-bit register offsets on both access paths.
 */
// How it works
// - override clear: address field shows captured strap address, writes to it ignored
// - override set: field writable, device answers there, reads show address in use
// - override select resets to 0 so strap address wins; 1 gives programmed address
// - writing 1 to bit 2 of soft reset register restarts rom load unless bit 0 is also set without bit 1, self-clearing
// - load-complete status sets once power-up or requested rom load finishes
// - bit 1 resets all logic and every configuration register, then clears itself
// - bit 0 resets logic but keeps configuration registers, then clears itself
// - bit 5 of global config enables the local bus master, 0 disables it
// - policy bit 4 at 0 and no assigned port locked: output goes high impedance
// - policy bit at 1: output keeps running; no assigned lock gives LP-11 when sleep select bit 2 and drive enable bit 3 are 1
// - sleep select 1 and drive enable bit 3 at 0 force outputs high impedance
// - sleep select bit 2 at 0 with policy bit 1: outputs driven HS-0 while lock is low
// - parity check enable bit 1, default 1, makes receivers check parity
// - per port, parity flag sets once error count reaches the 16-bit limit
// - refclk override bit 0 at 1 reports reference clock present, else detector
// - revision register read-only: silicon revision high nibble, mask revision low
// - registers reachable from local management bus and remote control channel
package deser_global_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BUS_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h01;
  localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h02;
  localparam logic [7:0] OFS_REVISION = 8'h03;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_OVERRIDE_SEL = 0;
  localparam int BIT_LOGIC_RESET = 0;
  localparam int BIT_FULL_RESET = 1;
  localparam int BIT_ROM_RELOAD = 2;
  localparam int BIT_REFCLK_OVR = 0;
  localparam int BIT_PARITY_EN = 1;
  localparam int BIT_SLEEP_SEL = 2;
  localparam int BIT_DRIVE_EN = 3;
  localparam int BIT_LOCKLESS_POLICY = 4;
  localparam int BIT_MASTER_EN = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET = 8'h1e;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'h3f;
  localparam logic [6:0] ADDRESS_RESET = 7'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SOFT_RESET_TIME_NS = 80;
  localparam int SOFT_RESET_CYCLES_INT = (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'(SOFT_RESET_CYCLES_INT);

  // ----------------------------------------------------------------
  // control states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_REQ = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_RUN = 4'b0100,
    ST_RST = 4'b1000
  } ctl_state_e;

endpackage : deser_global_pkg

/* File: hdl/deser_global_control_regs.sv */
/*
 * shared control and identification registers with boot/reset sequencing, output policy
 * and per-port parity error flags.
 * assumes the serial bus slave and the control channel each hand over single-byte
 * accesses on clk with req held until ack; lock, refclk detect and strap come from pins.
 */
module deser_global_control_regs
  import deser_global_pkg::*;
#(
  parameter logic [3:0] SILICON_REV = 4'h7, // arbitrary value
  parameter logic [3:0] MASK_REV = 4'h5 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic loc_req,
  input wire logic loc_we,
  input wire logic [7:0] loc_addr,
  input wire logic [7:0] loc_wdata,
  output logic loc_ack,
  output logic [7:0] loc_rdata,
  input wire logic rem_req,
  input wire logic rem_we,
  input wire logic [7:0] rem_addr,
  input wire logic [7:0] rem_wdata,
  output logic rem_ack,
  output logic [7:0] rem_rdata,
  input wire logic [6:0] strap_address,
  input wire logic rom_load_finished,
  input wire logic refclk_detected,
  input wire logic [3:0] rx_lock,
  input wire logic [3:0] port_assigned,
  input wire logic [3:0] parity_err_pulse,
  input wire logic [15:0] parity_error_limit,
  output logic [6:0] bus_address_field,
  output logic rom_load_req,
  output logic cfg_load_done,
  output logic logic_reset,
  output logic master_en,
  output logic parity_check_en,
  output logic refclk_present,
  output logic csi_hiz,
  output logic csi_lp11,
  output logic csi_hs0,
  output logic [3:0] parity_error_flag
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] strap_s1, strap_s2;
  logic [3:0] lock_s1, lock_s2;
  logic refclk_s1, refclk_s2;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_s1 <= ADDRESS_RESET;
      strap_s2 <= ADDRESS_RESET;
      lock_s1 <= 4'h0;
      lock_s2 <= 4'h0;
      refclk_s1 <= 1'b0;
      refclk_s2 <= 1'b0;
    end else begin
      strap_s1 <= strap_address;
      strap_s2 <= strap_s1;
      lock_s1 <= rx_lock;
      lock_s2 <= lock_s1;
      refclk_s1 <= refclk_detected;
      refclk_s2 <= refclk_s1;
    end
  end

  // ----------------------------------------------------------------
  // access arbitration
  // ----------------------------------------------------------------
  // local path wins a tie; the remote request simply waits one more cycle
  logic loc_take, rem_take, acc_take, acc_we;
  logic [7:0] acc_addr, acc_wdata;
  assign loc_take = loc_req && !loc_ack;
  assign rem_take = rem_req && !rem_ack && !loc_take;
  assign acc_take = loc_take || rem_take;
  assign acc_we = loc_take ? loc_we : rem_we;
  assign acc_addr = loc_take ? loc_addr : rem_addr;
  assign acc_wdata = loc_take ? loc_wdata : rem_wdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_addr, wr_reset, wr_cfg;
  assign wr_addr = acc_take && acc_we && hit(acc_addr, OFS_BUS_ADDRESS);
  assign wr_reset = acc_take && acc_we && hit(acc_addr, OFS_SOFT_RESET);
  assign wr_cfg = acc_take && acc_we && hit(acc_addr, OFS_GLOBAL_CONFIG);

  logic req_full, req_logic, req_reload;
  assign req_full = wr_reset && acc_wdata[BIT_FULL_RESET];
  assign req_logic = wr_reset && acc_wdata[BIT_LOGIC_RESET] && !req_full;
  assign req_reload = wr_reset && acc_wdata[BIT_ROM_RELOAD] && !req_full && !req_logic;

  // ----------------------------------------------------------------
  // boot and soft reset sequencing
  // ----------------------------------------------------------------
  ctl_state_e state, next_state;
  logic [3:0] rst_cnt;
  logic booted;
  logic reload_after_rst;

  always_comb begin
    next_state = state;
    case (state)
      ST_REQ: next_state = ST_LOAD;
      ST_LOAD: if (rom_load_finished) next_state = ST_RUN;
      ST_RUN: begin
        if (req_full || req_logic) begin
          next_state = ST_RST;
        end else if (req_reload) begin
          next_state = ST_REQ;
        end
      end
      ST_RST: begin
        if (rst_cnt == 4'h1) begin
          next_state = reload_after_rst ? ST_REQ : ST_RUN;
        end
      end
      default: next_state = ST_REQ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_REQ;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_cnt <= 4'h0;
      reload_after_rst <= 1'b0;
      logic_reset <= 1'b0;
    end else if (state == ST_RUN && (req_full || req_logic)) begin
      rst_cnt <= SOFT_RESET_CYCLES;
      reload_after_rst <= req_full;
      logic_reset <= 1'b1;
    end else if (state == ST_RST && rst_cnt != 4'h1) begin
      rst_cnt <= rst_cnt - 4'h1;
    end else begin
      rst_cnt <= 4'h0;
      logic_reset <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rom_load_req <= 1'b0;
      cfg_load_done <= 1'b0;
    end else begin
      rom_load_req <= (state == ST_REQ);
      if (state == ST_REQ) begin
        cfg_load_done <= 1'b0;
      end else if (state == ST_LOAD && rom_load_finished) begin
        cfg_load_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus address register
  // ----------------------------------------------------------------
  // strap is sampled only once, at the end of the first load after power-up
  logic [6:0] strap_latched, prog_address;
  logic override_sel;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      booted <= 1'b0;
      strap_latched <= ADDRESS_RESET;
    end else if (!booted && state == ST_LOAD && rom_load_finished) begin
      booted <= 1'b1;
      strap_latched <= strap_s2;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || req_full) begin
      override_sel <= 1'b0;
      prog_address <= ADDRESS_RESET;
    end else if (wr_addr) begin
      override_sel <= acc_wdata[BIT_OVERRIDE_SEL];
      if (acc_wdata[BIT_OVERRIDE_SEL]) begin
        prog_address <= acc_wdata[7:1];
      end
    end
  end

  logic [6:0] next_bus_address;
  assign next_bus_address = override_sel ? prog_address : strap_latched;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_address_field <= ADDRESS_RESET;
    end else begin
      bus_address_field <= next_bus_address;
    end
  end

  // ----------------------------------------------------------------
  // global configuration register
  // ----------------------------------------------------------------
  logic [7:0] cfg;

  always_ff @(posedge clk) begin
    if (!rst_n || req_full) begin
      cfg <= CONFIG_RESET;
    end else if (wr_cfg) begin
      cfg <= acc_wdata & CONFIG_WRITE_MASK;
    end
  end

  assign master_en = cfg[BIT_MASTER_EN];
  assign parity_check_en = cfg[BIT_PARITY_EN];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refclk_present <= 1'b0;
    end else begin
      refclk_present <= cfg[BIT_REFCLK_OVR] || refclk_s2;
    end
  end

  // ----------------------------------------------------------------
  // output port policy
  // ----------------------------------------------------------------
  logic any_lock;
  assign any_lock = |(lock_s2 & port_assigned);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      csi_hiz <= 1'b1;
      csi_lp11 <= 1'b0;
      csi_hs0 <= 1'b0;
    end else if (cfg[BIT_SLEEP_SEL] && !cfg[BIT_DRIVE_EN]) begin
      csi_hiz <= 1'b1;
      csi_lp11 <= 1'b0;
      csi_hs0 <= 1'b0;
    end else if (any_lock) begin
      csi_hiz <= 1'b0;
      csi_lp11 <= 1'b0;
      csi_hs0 <= 1'b0;
    end else if (!cfg[BIT_LOCKLESS_POLICY]) begin
      csi_hiz <= 1'b1;
      csi_lp11 <= 1'b0;
      csi_hs0 <= 1'b0;
    end else begin
      csi_hiz <= 1'b0;
      csi_lp11 <= cfg[BIT_SLEEP_SEL];
      csi_hs0 <= !cfg[BIT_SLEEP_SEL];
    end
  end

  // ----------------------------------------------------------------
  // per-port parity error counting
  // ----------------------------------------------------------------
  // counters saturate so a long run of errors cannot wrap below the limit
  logic [15:0] par_cnt [4];

  for (genvar p = 0; p < 4; p++) begin : g_parity
    always_ff @(posedge clk) begin
      if (!rst_n || logic_reset) begin
        par_cnt[p] <= 16'h0000;
        parity_error_flag[p] <= 1'b0;
      end else begin
        if (parity_check_en && parity_err_pulse[p] && par_cnt[p] != 16'hffff) begin
          par_cnt[p] <= par_cnt[p] + 16'h0001;
        end
        parity_error_flag[p] <= (par_cnt[p] >= parity_error_limit);
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and acknowledge
  // ----------------------------------------------------------------
  logic [7:0] rd_value;

  always_comb begin
    case (acc_addr)
      OFS_BUS_ADDRESS: rd_value = {next_bus_address, override_sel};
      OFS_SOFT_RESET: rd_value = 8'h00;
      OFS_GLOBAL_CONFIG: rd_value = cfg;
      OFS_REVISION: rd_value = {SILICON_REV, MASK_REV};
      default: rd_value = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loc_ack <= 1'b0;
      rem_ack <= 1'b0;
      loc_rdata <= 8'h00;
      rem_rdata <= 8'h00;
    end else begin
      loc_ack <= loc_take;
      rem_ack <= rem_take;
      if (loc_take && !loc_we) begin
        loc_rdata <= rd_value;
      end
      if (rem_take && !rem_we) begin
        rem_rdata <= rd_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_strap_used: assert property (!override_sel |=> bus_address_field == $past(strap_latched))
    else $error("strap address not presented");
  a_prog_address: assert property (wr_addr && acc_wdata[0] && !req_full
    |=> ##1 bus_address_field == $past(acc_wdata[7:1], 2))
    else $error("programmed address not in use");
  a_full_clears_sel: assert property (req_full |=> !override_sel && cfg == CONFIG_RESET)
    else $error("full reset left configuration");
  a_reload_restart: assert property (state == ST_RUN && req_reload |=> ##1 rom_load_req ##1 !rom_load_req)
    else $error("reload not restarted");
  a_load_done: assert property (state == ST_LOAD && rom_load_finished |=> cfg_load_done)
    else $error("load done not set");
  a_logic_keeps_cfg: assert property (req_logic && state == ST_RUN && !wr_cfg
    |=> (logic_reset && $stable(cfg)) [*4])
    else $error("logic reset disturbed configuration");
  a_reset_length: assert property ($rose(logic_reset) |-> logic_reset [*4] ##1 !logic_reset)
    else $error("soft reset length wrong");
  a_hiz_no_lock: assert property (!cfg[4] && !any_lock |=> csi_hiz)
    else $error("output not high impedance without lock");
  a_lp11_policy: assert property (cfg[4] && cfg[2] && cfg[3] && !any_lock |=> csi_lp11 && !csi_hiz)
    else $error("lp11 not entered");
  a_sleep_hiz: assert property (cfg[2] && !cfg[3] |=> csi_hiz && !csi_hs0)
    else $error("sleep drive off not high impedance");
  a_refclk_force: assert property (cfg[0] |=> refclk_present)
    else $error("refclk override ignored");
  a_rev_read: assert property (loc_take && !loc_we && loc_addr == OFS_REVISION
    |=> loc_ack && loc_rdata == {SILICON_REV, MASK_REV})
    else $error("revision read wrong");
  a_selfclear_read: assert property (loc_take && !loc_we && loc_addr == OFS_SOFT_RESET
    |=> loc_rdata == 8'h00)
    else $error("reset bits read nonzero");

endmodule : deser_global_control_regs

/* File: test/rom_loader_model.sv */
/*
 * behavioural rom loader on the far side of the bank's load port: answers a load
 * request with a one-cycle finished pulse after a short or a long delay.
 * assumes the bank's clock and its synchronous active-low reset.
 */
module rom_loader_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rom_load_req,
  input wire logic slow,
  output logic rom_load_finished
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // load timer
  // ----------------------------------------------------------------
  // slow loads leave the bank polling its done flag for a while
  int cnt;
  always @(posedge clk) begin
    rom_load_finished <= 1'b0;
    if (!rst_n) begin
      cnt <= 0;
    end else if (rom_load_req) begin
      cnt <= slow ? 40 : 3;
    end else if (cnt == 1) begin
      cnt <= 0;
      rom_load_finished <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : rom_loader_model

/* File: test/deser_global_control_regs_tb.sv */
/*
 * self-checking bench of the shared control register bank against an integer model.
 * assumes both access paths follow the req/ack hand-over and a rom loader model on the load port.
 */
module deser_global_control_regs_tb
  import deser_global_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [3:0] SI_REV = 4'h3; // arbitrary value
  localparam logic [3:0] MK_REV = 4'hc; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] req = 2'b00;
  logic we = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [6:0] strap = 7'h00;
  logic slow = 1'b0;
  logic refdet = 1'b0;
  logic [3:0] lock = 4'h0;
  logic [3:0] perr = 4'h0;
  logic [3:0] assigned = 4'h1;
  logic [15:0] limit = 16'h0000;
  logic loc_ack, rem_ack, fin, ldreq, done, lrst, men, pen, refp, hiz, lp11, hs0;
  logic [7:0] loc_rdata, rem_rdata;
  logic [6:0] baddr;
  logic [3:0] pflag;
  int n_errors = 0;
  int checked = 0;
  int m_cfg = 8'h1e;
  logic m_ovr = 1'b0;
  logic [6:0] m_addr = 7'h00;

  deser_global_control_regs #(.SILICON_REV(SI_REV), .MASK_REV(MK_REV)) uut (
    .clk(clk), .rst_n(rst_n),
    .loc_req(req[0]), .loc_we(we), .loc_addr(addr), .loc_wdata(wdata), .loc_ack(loc_ack), .loc_rdata(loc_rdata),
    .rem_req(req[1]), .rem_we(we), .rem_addr(addr), .rem_wdata(wdata), .rem_ack(rem_ack), .rem_rdata(rem_rdata),
    .strap_address(strap), .rom_load_finished(fin), .refclk_detected(refdet), .rx_lock(lock),
    .port_assigned(assigned), .parity_err_pulse(perr), .parity_error_limit(limit),
    .bus_address_field(baddr), .rom_load_req(ldreq), .cfg_load_done(done), .logic_reset(lrst),
    .master_en(men), .parity_check_en(pen), .refclk_present(refp),
    .csi_hiz(hiz), .csi_lp11(lp11), .csi_hs0(hs0), .parity_error_flag(pflag)
  );

  rom_loader_model loader (.clk(clk), .rst_n(rst_n), .rom_load_req(ldreq), .slow(slow), .rom_load_finished(fin));

  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    logic [6:0] in_use;
    in_use = m_ovr ? m_addr : strap;
    case (a)
      OFS_BUS_ADDRESS: return {in_use, m_ovr};
      OFS_GLOBAL_CONFIG: return 8'(m_cfg);
      OFS_REVISION: return {SI_REV, MK_REV};
      default: return 8'h00;
    endcase
  endfunction : exp_reg

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // request held until ack is sampled, released on that same edge
  task automatic acc(input bit r, input bit w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int i;
    @(posedge clk);
    req[r] <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if ((r ? rem_ack : loc_ack) === 1'b1) break;
    end
    q = r ? rem_rdata : loc_rdata;
    req[r] <= 1'b0;
    if (i == 20) begin
      n_errors++;
      results();
    end
  endtask : acc

  task automatic wr(input bit r, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(r, 1'b1, a, d, q);
    if (a == OFS_GLOBAL_CONFIG) m_cfg = d & 8'h3f;
    if (a == OFS_BUS_ADDRESS) begin
      m_ovr = d[0];
      if (d[0]) m_addr = d[7:1];
    end
  endtask : wr

  task automatic rd(input bit r, input logic [7:0] a);
    logic [7:0] q;
    acc(r, 1'b0, a, 8'h00, q);
    chk(q, exp_reg(a));
  endtask : rd

  // lvl 1: wait for load done, lvl 0: wait for the logic reset to end
  task automatic wait_for(input bit lvl);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (lvl ? (done === 1'b1) : (lrst === 1'b0)) break;
    end
    if (i == 300) begin
      n_errors++;
      results();
    end
  endtask : wait_for

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    perr <= m;
    @(posedge clk);
    perr <= 4'h0;
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [3:0] p, asg;
    logic eh, el, es;
    void'($urandom(32'h0000_6300));
    strap <= 7'($urandom);
    tick(2);
    rst_n <= 1'b1;
    wait_for(1'b1);
    chk({7'h00, done}, 8'h01);
    rd(1'b0, OFS_BUS_ADDRESS);
    rd(1'b1, OFS_SOFT_RESET);
    rd(1'b0, OFS_GLOBAL_CONFIG);
    rd(1'b1, OFS_REVISION);
    for (int k = 0; k < 6; k++) begin
      d = 8'($urandom);
      d[0] = k[1];
      wr(k[0], OFS_BUS_ADDRESS, d);
      rd(!k[0], OFS_BUS_ADDRESS);
      chk({baddr, m_ovr}, exp_reg(OFS_BUS_ADDRESS));
    end
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      d[0] = k[1];
      refdet <= 1'($urandom);
      wr(k[0], OFS_GLOBAL_CONFIG, d);
      wr(!k[0], OFS_REVISION, ~d);
      wr(k[0], 8'h40 + 8'(k), d);
      tick(3);
      rd(k[0], OFS_GLOBAL_CONFIG);
      rd(!k[0], OFS_REVISION);
      rd(!k[0], 8'h40 + 8'(k));
      chk({6'h00, men, pen}, {6'h00, d[5], d[1]});
      chk({7'h00, refp}, {7'h00, d[0] | refdet});
    end
    // unlocked cases lock every unassigned port, which must not count
    for (int k = 0; k < 16; k++) begin
      p = 4'(k);
      asg = 4'($urandom_range(15, 1));
      assigned <= asg;
      lock <= p[3] ? (asg & ~(asg - 4'h1)) : ~asg;
      wr(p[0], OFS_GLOBAL_CONFIG, {3'b000, p[0], p[2], p[1], 2'b10});
      tick(4);
      eh = p[1] & !p[2];
      el = 1'b0;
      es = 1'b0;
      if (!eh && !p[3]) begin
        eh = !p[0];
        el = p[0] & p[1];
        es = p[0] & !p[1];
      end
      chk({5'h00, hiz, lp11, hs0}, {5'h00, eh, el, es});
    end
    limit <= 16'h0003;
    wr(1'b0, OFS_GLOBAL_CONFIG, 8'h1e);
    wr(1'b1, OFS_SOFT_RESET, 8'h01);
    chk({7'h00, lrst}, 8'h01);
    wait_for(1'b0);
    rd(1'b0, OFS_GLOBAL_CONFIG);
    chk({4'h0, pflag}, 8'h00);
    repeat (2) pulse(4'h1);
    tick(3);
    chk({4'h0, pflag}, 8'h00);
    pulse(4'h1);
    tick(3);
    chk({4'h0, pflag}, 8'h01);
    wr(1'b0, OFS_GLOBAL_CONFIG, 8'h1c);
    wr(1'b0, OFS_SOFT_RESET, 8'h01);
    wait_for(1'b0);
    repeat (4) pulse(4'h2);
    tick(3);
    chk({4'h0, pflag}, 8'h00);
    wr(1'b1, OFS_BUS_ADDRESS, 8'h55);
    wr(1'b0, OFS_SOFT_RESET, 8'h07);
    m_cfg = 8'h1e;
    m_ovr = 1'b0;
    wait_for(1'b0);
    wait_for(1'b1);
    rd(1'b0, OFS_GLOBAL_CONFIG);
    rd(1'b1, OFS_BUS_ADDRESS);
    slow <= 1'b1;
    wr(1'b1, OFS_SOFT_RESET, 8'h04);
    tick(1);
    chk({6'h00, ldreq, done}, 8'h02);
    rd(1'b0, OFS_SOFT_RESET);
    wait_for(1'b1);
    chk({7'h00, done}, 8'h01);
    results();
  end
endmodule : deser_global_control_regs_tb
